// ===== logic/jit_pkg.sv
package jit_pkg;
    localparam logic [7:0] OFS_TX_CTRL = 8'h3B;
    localparam logic [7:0] OFS_STATE_VEC = 8'h3C;
    localparam logic [7:0] OFS_DATA = 8'h3D;
    localparam int BIT_NORM_BIT_FORMAT_SELECT = 4;
    localparam int BIT_END_OF_DATA_REQUEST = 3;
    localparam int BIT_SINGLE = 2;
    localparam logic [3:0] CFG_RST = 4'hC;
    localparam logic [2:0] ACT_SINGLE = 3'h4;
    localparam logic [2:0] ACT_MCRC = 3'h2;
    localparam logic [2:0] ACT_MNOCRC = 3'h1;
    localparam int SV_STEP = 4;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    localparam logic [7:0] CRC_POLY = 8'h1D;

    typedef enum logic [2:0] {SYM_NB, SYM_BYTE, SYM_CRC, SYM_EOD, SYM_ONES} jit_sym_t;

    typedef struct packed {
        jit_sym_t kind;
        logic level;
        logic [7:0] data;
    } jit_tx_cmd_t;

    typedef struct packed {
        logic eod_ok;
        logic eof;
        logic bus_err;
        logic arb_lost;
        logic arb_late;
        logic win_done;
        logic tx_done;
    } jit_link_ev_t;

    typedef struct packed {
        logic wakeup;
        logic sym_inv;
        logic crc_err;
        logic rdrf;
        logic rxifr;
        logic eof;
    } jit_rx_flags_t;
endpackage : jit_pkg

// ===== logic/jit_crc8.sv
`timescale 1ns/1ps
`default_nettype none
module jit_crc8 (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic init,
    input wire logic load,
    input wire logic [7:0] data,
    output logic [7:0] crc
);
    import jit_pkg::*;
    logic [7:0] crc_reg;
    logic [7:0] crc_next;

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[7] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_step

    always_comb begin
        crc_next = crc_reg;
        if (init) begin
            crc_next = CRC_INIT;
        end else if (load) begin
            crc_next = crc_step(crc_reg, data);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            crc_reg <= CRC_INIT;
        end else if (ce) begin
            crc_reg <= crc_next;
        end
    end

    // Sent inverted, as the link checks the complement
    assign crc = ~crc_reg;
endmodule : jit_crc8
`default_nettype wire

// ===== logic/jit_state_vec.sv
`timescale 1ns/1ps
`default_nettype none
module jit_state_vec (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [8:1] src,
    output logic [7:0] vec
);
    import jit_pkg::*;
    logic [7:0] vec_reg;
    logic [7:0] vec_next;
    logic [3:0] idx;

    always_comb begin
        idx = 4'h0;
        for (int i = 1; i <= 8; i++) begin
            if (src[i]) begin
                idx = 4'(i);
            end
        end
        vec_next = 8'(32'(idx) * SV_STEP);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            vec_reg <= 8'h00;
        end else if (ce) begin
            vec_reg <= vec_next;
        end
    end

    assign vec = vec_reg;

    AST_VEC_WAKEUP: assert property (@(posedge ref_clk) disable iff (srst)
        ce && src[8] |=> vec == 8'h20)
        else $error("Wakeup does not give the top vector");
endmodule : jit_state_vec
`default_nettype wire

// ===== logic/jit_ifr_ctrl.sv
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module jit_ifr_ctrl (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] rx_data,
    input wire jit_pkg::jit_rx_flags_t rx_flags,
    input wire jit_pkg::jit_link_ev_t link_ev,
    output logic tx_valid,
    input wire logic tx_ready,
    output jit_pkg::jit_tx_cmd_t tx_cmd
);
    import jit_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_NB, ST_BYTE, ST_CRC, ST_EOD, ST_ONES, ST_RETRY} jit_state_t;

    jit_state_t st_reg, st_next;
    logic taken_reg, taken_next;
    logic retry_reg, retry_next;
    logic [2:0] req_reg, req_next;
    logic end_of_data_request_reg, end_of_data_request_next;
    logic [3:0] cfg_reg, cfg_next;
    logic [7:0] data_reg, data_next;
    logic full_reg, full_next;
    logic tx_data_empty_flag_reg, tx_data_empty_flag_next;
    logic loss_reg, loss_next;
    logic eod_seen_reg, eod_seen_next;
    logic [7:0] sh_reg, sh_next;
    logic [7:0] rdata_reg, rdata_next;
    logic valid_reg, valid_next;
    jit_tx_cmd_t cmd_reg, cmd_next;
    logic [2:0] act;
    logic crc_init, crc_load;
    logic [7:0] crc_val;
    logic [7:0] vec;
    logic wr_ctl, sending, with_crc;

    jit_crc8 u_crc (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .init(crc_init),
        .load(crc_load),
        .data(data_reg),
        .crc(crc_val)
    );

    jit_state_vec u_vec (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .src({rx_flags.wakeup, rx_flags.sym_inv, rx_flags.crc_err, loss_reg,
              tx_data_empty_flag_reg, rx_flags.rdrf, rx_flags.rxifr, rx_flags.eof}),
        .vec(vec)
    );

    // Only one request acts inside; reads still show the written bits
    always_comb begin
        if (req_reg[2]) begin
            act = ACT_SINGLE;
        end else if (req_reg[1]) begin
            act = ACT_MCRC;
        end else if (req_reg[0]) begin
            act = ACT_MNOCRC;
        end else begin
            act = 3'h0;
        end
    end

    assign wr_ctl = reg_wr && (reg_addr == OFS_TX_CTRL);
    assign sending = (st_reg != ST_IDLE) && (st_reg != ST_RETRY);
    assign with_crc = act[1];

    always_comb begin
        st_next = st_reg;
        taken_next = taken_reg;
        retry_next = retry_reg;
        req_next = req_reg;
        end_of_data_request_next = end_of_data_request_reg;
        cfg_next = cfg_reg;
        data_next = data_reg;
        full_next = full_reg;
        tx_data_empty_flag_next = tx_data_empty_flag_reg;
        loss_next = loss_reg;
        eod_seen_next = eod_seen_reg;
        sh_next = sh_reg;
        crc_init = 1'b0;
        crc_load = 1'b0;
        // Software side first, so hardware events below win the same cycle
        if (wr_ctl) begin
            cfg_next = reg_wdata[7:BIT_NORM_BIT_FORMAT_SELECT];
            // After EOD a request bit may be cleared but not set
            req_next = eod_seen_reg ? (req_reg & reg_wdata[2:0]) : reg_wdata[2:0];
            if (reg_wdata[BIT_END_OF_DATA_REQUEST]) begin
                end_of_data_request_next = 1'b1;
                tx_data_empty_flag_next = 1'b0;
                req_next[BIT_SINGLE] = 1'b0;
            end
        end
        if (reg_wr && reg_addr == OFS_DATA) begin
            data_next = reg_wdata;
            full_next = 1'b1;
            tx_data_empty_flag_next = 1'b0;
        end
        if (reg_rd && reg_addr == OFS_STATE_VEC) begin
            loss_next = 1'b0;
            if (loss_reg || rx_flags.sym_inv) begin
                tx_data_empty_flag_next = 1'b0;
            end
        end
        if (link_ev.eod_ok) begin
            eod_seen_next = 1'b1;
        end
        if (link_ev.eof) begin
            eod_seen_next = 1'b0;
        end
        if (sending && tx_ready && valid_reg) begin
            taken_next = 1'b1;
        end
        case (st_reg)
            ST_IDLE: begin
                if (link_ev.eod_ok && act != 3'h0) begin
                    st_next = ST_NB;
                    taken_next = 1'b0;
                    retry_next = 1'b0;
                    crc_init = 1'b1;
                end
            end
            ST_NB: begin
                if (link_ev.tx_done && taken_reg) begin
                    st_next = ST_BYTE;
                    taken_next = 1'b0;
                end
            end
            ST_BYTE: begin
                if (tx_ready && valid_reg && !retry_reg) begin
                    sh_next = data_reg;
                    full_next = 1'b0;
                    crc_load = 1'b1;
                    // Preloaded byte with end-of-data set gives no data-empty
                    if (act != ACT_SINGLE && !end_of_data_request_next) begin
                        tx_data_empty_flag_next = 1'b1;
                    end
                end
                if (link_ev.tx_done && taken_reg) begin
                    taken_next = 1'b0;
                    if (act == ACT_SINGLE) begin
                        req_next = 3'h0;
                        st_next = ST_IDLE;
                    end else if (full_reg) begin
                        // A refilled byte goes out before any CRC or EOD
                        st_next = ST_BYTE;
                    end else if (end_of_data_request_reg) begin
                        st_next = with_crc ? ST_CRC : ST_EOD;
                    end else if (!full_reg) begin
                        // Underrun: abort on a non-byte boundary
                        req_next = 3'h0;
                        st_next = ST_ONES;
                    end
                end
            end
            ST_CRC: begin
                if (tx_ready && valid_reg) begin
                    end_of_data_request_next = 1'b0;
                end
                if (link_ev.tx_done && taken_reg) begin
                    st_next = ST_EOD;
                    taken_next = 1'b0;
                end
            end
            ST_EOD: begin
                if (link_ev.tx_done && taken_reg) begin
                    req_next = 3'h0;
                    end_of_data_request_next = 1'b0;
                    st_next = ST_IDLE;
                end
            end
            ST_ONES: begin
                if (link_ev.tx_done && taken_reg) begin
                    st_next = ST_IDLE;
                end
            end
            ST_RETRY: begin
                if (act != ACT_SINGLE) begin
                    st_next = ST_IDLE;
                end else if (link_ev.win_done) begin
                    st_next = ST_BYTE;
                    taken_next = 1'b0;
                    retry_next = 1'b1;
                end
            end
            default: begin
                st_next = ST_IDLE;
            end
        endcase
        if (sending && link_ev.arb_lost) begin
            taken_next = 1'b0;
            if (act == ACT_SINGLE) begin
                // Retry from the shift copy; never the extra ones
                st_next = ST_RETRY;
                if (st_reg == ST_NB) begin
                    sh_next = data_reg;
                end
            end else begin
                loss_next = 1'b1;
                req_next = 3'h0;
                st_next = link_ev.arb_late ? ST_ONES : ST_IDLE;
            end
        end
        if (link_ev.bus_err) begin
            req_next = 3'h0;
            end_of_data_request_next = 1'b0;
            taken_next = 1'b0;
            eod_seen_next = 1'b0;
            st_next = ST_IDLE;
        end
    end

    // Registered link command, built from the next state
    always_comb begin
        valid_next = (st_next != ST_IDLE) && (st_next != ST_RETRY) && !taken_next;
        cmd_next.kind = SYM_NB;
        cmd_next.level = with_crc ? ~cfg_next[0] : cfg_next[0];
        cmd_next.data = 8'h00;
        case (st_next)
            ST_BYTE: begin
                cmd_next.kind = SYM_BYTE;
                cmd_next.data = retry_next ? sh_next : data_next;
            end
            ST_CRC: begin
                cmd_next.kind = SYM_CRC;
                cmd_next.data = crc_val;
            end
            ST_EOD: begin
                cmd_next.kind = SYM_EOD;
            end
            ST_ONES: begin
                cmd_next.kind = SYM_ONES;
            end
            default: begin
                cmd_next.kind = SYM_NB;
            end
        endcase
        rdata_next = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                OFS_TX_CTRL: rdata_next = {cfg_reg, end_of_data_request_reg, req_reg};
                OFS_STATE_VEC: rdata_next = vec;
                OFS_DATA: rdata_next = rx_data;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_reg <= ST_IDLE;
            taken_reg <= 1'b0;
            retry_reg <= 1'b0;
            req_reg <= 3'h0;
            end_of_data_request_reg <= 1'b0;
            cfg_reg <= CFG_RST;
            data_reg <= 8'h00;
            full_reg <= 1'b0;
            tx_data_empty_flag_reg <= 1'b0;
            loss_reg <= 1'b0;
            eod_seen_reg <= 1'b0;
            sh_reg <= 8'h00;
            rdata_reg <= 8'h00;
            valid_reg <= 1'b0;
            cmd_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
            taken_reg <= taken_next;
            retry_reg <= retry_next;
            req_reg <= req_next;
            end_of_data_request_reg <= end_of_data_request_next;
            cfg_reg <= cfg_next;
            data_reg <= data_next;
            full_reg <= full_next;
            tx_data_empty_flag_reg <= tx_data_empty_flag_next;
            loss_reg <= loss_next;
            eod_seen_reg <= eod_seen_next;
            sh_reg <= sh_next;
            rdata_reg <= rdata_next;
            valid_reg <= valid_next;
            cmd_reg <= cmd_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign tx_valid = valid_reg;
    assign tx_cmd = cmd_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_eod_done;
        ce && st_reg == ST_EOD && taken_reg && link_ev.tx_done && !link_ev.bus_err && !link_ev.arb_lost;
    endsequence

    sequence s_start;
        ce && st_reg == ST_IDLE && link_ev.eod_ok && act != 3'h0 && !link_ev.bus_err;
    endsequence

    AST_PRIO: assert property (req_reg[2] |-> act == ACT_SINGLE)
        else $error("Single request does not win");
    AST_READBACK: assert property (ce && wr_ctl && !eod_seen_reg && st_reg == ST_IDLE && !reg_wdata[BIT_END_OF_DATA_REQUEST]
        && !link_ev.bus_err |=> req_reg == $past(reg_wdata[2:0]))
        else $error("Request bits not kept as written");
    AST_START: assert property (s_start |=> st_reg == ST_NB && valid_reg && tx_cmd.kind == SYM_NB)
        else $error("No response started at EOD");
    AST_NO_REQ: assert property (st_reg == ST_IDLE && act == 3'h0 |=> st_reg == ST_IDLE)
        else $error("Response started without request");
    AST_LATE_SET: assert property (ce && eod_seen_reg && req_reg == 3'h0 && wr_ctl |=> req_reg == 3'h0)
        else $error("Request set after EOD");
    AST_TX_DATA_EMPTY_FLAG: assert property (ce && st_reg == ST_BYTE && valid_reg && tx_ready && !retry_reg
        && act != ACT_SINGLE && !end_of_data_request_reg && !reg_wr && !link_ev.bus_err && !link_ev.arb_lost
        |=> tx_data_empty_flag_reg)
        else $error("Data-empty not raised");
    AST_SINGLE_LOSS: assert property (ce && sending && act == ACT_SINGLE && link_ev.arb_lost
        && !link_ev.bus_err |=> st_reg == ST_RETRY && !valid_reg)
        else $error("Single loss does not wait to retry");
    AST_MULTI_LATE: assert property (ce && sending && act != ACT_SINGLE && link_ev.arb_lost
        && link_ev.arb_late && !link_ev.bus_err
        |=> st_reg == ST_ONES && req_reg == 3'h0 && loss_reg ##1 !ce || tx_cmd.kind == SYM_ONES)
        else $error("Late multi loss mishandled");
    AST_EOD_DONE: assert property (s_eod_done |=> st_reg == ST_IDLE && req_reg == 3'h0 && !valid_reg)
        else $error("Request not cleared after EOD");
    AST_BUS_ERR: assert property (ce && link_ev.bus_err |=> req_reg == 3'h0 && st_reg == ST_IDLE)
        else $error("Bus error did not clear request");
endmodule : jit_ifr_ctrl
`default_nettype wire

// ===== tb/jit_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module jit_link_model (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic tx_valid,
    input wire jit_pkg::jit_tx_cmd_t tx_cmd,
    input wire logic lose_arm,
    input wire logic lose_late,
    input wire jit_pkg::jit_link_ev_t ext_ev,
    output logic tx_ready,
    output jit_pkg::jit_link_ev_t link_ev
);
    import jit_pkg::*;
    integer seed = 15;
    logic [1:0] st = 2'h0;
    logic [4:0] cnt = 5'h00;
    logic armed = 1'b0;
    logic lost = 1'b0;
    jit_link_ev_t own = '0;
    jit_link_ev_t nx;
    // Frame events from the bench ride alongside our own completion events
    assign link_ev = own | ext_ev;
    initial tx_ready = 1'b0;
    always @(posedge ref_clk) begin
        nx = '0;
        if (srst) begin
            st <= 2'h0;
            tx_ready <= 1'b0;
            cnt <= 5'h00;
            armed <= 1'b0;
            lost <= 1'b0;
        end else begin
            if (lose_arm) begin
                armed <= 1'b1;
            end
            case (st)
                2'h0: begin
                    if (tx_valid && tx_ready) begin
                        tx_ready <= 1'b0;
                        // Only a data byte can be beaten by another responder
                        lost <= armed && (tx_cmd.kind == SYM_BYTE);
                        // Long symbol time leaves software room to refill
                        cnt <= 5'h08 + 5'($unsigned($random(seed)) % 4);
                        st <= 2'h1;
                    end else if (tx_valid) begin
                        if (cnt == 5'h00) begin
                            tx_ready <= 1'b1;
                        end else begin
                            cnt <= cnt - 5'h01;
                        end
                    end
                end
                2'h1: begin
                    if (cnt != 5'h00) begin
                        cnt <= cnt - 5'h01;
                    end else if (lost) begin
                        nx.arb_lost = 1'b1;
                        nx.arb_late = lose_late;
                        armed <= 1'b0;
                        lost <= 1'b0;
                        cnt <= 5'h06;
                        st <= 2'h2;
                    end else begin
                        nx.tx_done = 1'b1;
                        cnt <= 5'($unsigned($random(seed)) % 3);
                        st <= 2'h0;
                    end
                end
                default: begin
                    if (cnt != 5'h00) begin
                        cnt <= cnt - 5'h01;
                    end else begin
                        nx.win_done = 1'b1;
                        st <= 2'h0;
                    end
                end
            endcase
        end
        own <= nx;
    end
endmodule : jit_link_model
`default_nettype wire

// ===== tb/jit_ifr_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module jit_ifr_ctrl_test;
    import jit_pkg::*;
    localparam jit_link_ev_t EV_EOD = 7'h40;
    localparam jit_link_ev_t EV_EOF = 7'h20;
    localparam logic [11:0] ML = 12'hF00;
    localparam logic [11:0] MK = 12'hE00;
    localparam logic [11:0] MD = 12'hEFF;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] rx_data = 8'h00;
    jit_rx_flags_t rx_flags = '0;
    jit_link_ev_t ext_ev = '0;
    jit_link_ev_t link_ev;
    logic lose_arm = 1'b0;
    logic lose_late = 1'b1;
    logic tx_valid;
    logic tx_ready;
    jit_tx_cmd_t tx_cmd;
    integer seed = 15;
    int fail_count = 0;
    int comparisons = 0;
    logic [7:0] rq[$];
    logic [23:0] tq[$];
    logic [23:0] e;
    logic rd_pend = 1'b0;
    logic [7:0] d;
    logic [7:0] d2;
    logic [7:0] vtab [6] = '{8'h04, 8'h08, 8'h0C, 8'h18, 8'h1C, 8'h20};
    int i;
    always #5 ref_clk = ~ref_clk;
    jit_ifr_ctrl uut (.ref_clk(ref_clk), .srst(srst), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_data(rx_data), .rx_flags(rx_flags),
        .link_ev(link_ev), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_cmd(tx_cmd));
    jit_link_model link (.ref_clk(ref_clk), .srst(srst), .tx_valid(tx_valid), .tx_cmd(tx_cmd),
        .lose_arm(lose_arm), .lose_late(lose_late), .ext_ev(ext_ev), .tx_ready(tx_ready), .link_ev(link_ev));
    task chk(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    // Gap cycle after each strobe keeps one assignment per signal per step
    task wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] exp);
        rq.push_back(exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
    endtask : rd
    task ex(input jit_sym_t k, input logic lv, input logic [7:0] dt, input logic [11:0] m);
        tq.push_back({m, k, lv, dt});
    endtask : ex
    task ev(input jit_link_ev_t v);
        ext_ev <= v;
        @(posedge ref_clk);
        ext_ev <= '0;
        @(posedge ref_clk);
    endtask : ev
    task arm;
        lose_arm <= 1'b1;
        @(posedge ref_clk);
        lose_arm <= 1'b0;
    endtask : arm
    task wait_q;
        int w;
        for (w = 0; w < 300 && tq.size() != 0; w++) begin
            @(posedge ref_clk);
        end
    endtask : wait_q
    task settle;
        wait_q();
        chk(12'(tq.size()), 12'h000);
        repeat (25) @(posedge ref_clk);
    endtask : settle
    always @(posedge ref_clk) begin
        if (rd_pend) begin
            chk(12'(reg_rdata), 12'(rq.pop_front()));
        end
        rd_pend <= reg_rd;
        if (tx_valid && tq.size() == 0) begin
            chk(12'h001, 12'h000);
        end else if (tx_valid && tx_ready) begin
            e = tq.pop_front();
            chk(tx_cmd & e[23:12], e[11:0] & e[23:12]);
        end
    end
    initial begin
        #200000;
        fail_count++;
        final_report();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        rd(OFS_TX_CTRL, 8'hC0);
        rd(OFS_STATE_VEC, 8'h00);
        wr(8'h40, 8'hFF);
        rd(8'h40, 8'h00);
        d = 8'($random(seed));
        rx_data <= d;
        rd(OFS_DATA, d);
        for (i = 0; i < 6; i++) begin
            rx_flags <= jit_rx_flags_t'(6'h01 << i);
            repeat (3) @(posedge ref_clk);
            rd(OFS_STATE_VEC, vtab[i]);
        end
        rx_flags <= jit_rx_flags_t'(6'h21);
        repeat (3) @(posedge ref_clk);
        rd(OFS_STATE_VEC, 8'h20);
        rx_flags <= '0;
        for (i = 0; i < 8; i++) begin
            wr(OFS_TX_CTRL, 8'hC0 | 8'(i));
            rd(OFS_TX_CTRL, 8'hC0 | 8'(i));
        end
        // Two requests at once, byte preloaded, end of data after the EOD
        d = 8'($random(seed));
        wr(OFS_DATA, d);
        wr(OFS_TX_CTRL, 8'hC3);
        ex(SYM_NB, 1'b1, 8'h00, ML);
        ex(SYM_BYTE, 1'b0, d, MD);
        ex(SYM_CRC, 1'b0, 8'h00, MK);
        ex(SYM_EOD, 1'b0, 8'h00, MK);
        ev(EV_EOD);
        wr(OFS_TX_CTRL, 8'hCB);
        settle();
        rd(OFS_STATE_VEC, 8'h00);
        ev(EV_EOF);
        wr(OFS_TX_CTRL, 8'hC0);
        // Two bytes without CRC, refilled after the data-empty event
        d = 8'($random(seed));
        d2 = 8'($random(seed));
        wr(OFS_DATA, d);
        wr(OFS_TX_CTRL, 8'hD1);
        ex(SYM_NB, 1'b1, 8'h00, ML);
        ex(SYM_BYTE, 1'b0, d, MD);
        ev(EV_EOD);
        wait_q();
        // The vector trails the flag by one register stage
        repeat (2) @(posedge ref_clk);
        rd(OFS_STATE_VEC, 8'h10);
        wr(OFS_DATA, d2);
        wr(OFS_TX_CTRL, 8'hD9);
        ex(SYM_BYTE, 1'b0, d2, MD);
        ex(SYM_EOD, 1'b0, 8'h00, MK);
        settle();
        rd(OFS_TX_CTRL, 8'hD0);
        ev(EV_EOF);
        // No refill: underrun ends the response
        d = 8'($random(seed));
        wr(OFS_DATA, d);
        wr(OFS_TX_CTRL, 8'hD2);
        ex(SYM_NB, 1'b0, 8'h00, ML);
        ex(SYM_BYTE, 1'b0, d, MD);
        ex(SYM_ONES, 1'b0, 8'h00, MK);
        ev(EV_EOD);
        settle();
        rd(OFS_TX_CTRL, 8'hD0);
        ev(EV_EOF);
        // Late arbitration loss with CRC: one ones symbol, no retry
        d = 8'($random(seed));
        wr(OFS_DATA, d);
        wr(OFS_TX_CTRL, 8'hC2);
        arm();
        ex(SYM_NB, 1'b1, 8'h00, ML);
        ex(SYM_BYTE, 1'b0, d, MD);
        ex(SYM_ONES, 1'b0, 8'h00, MK);
        ev(EV_EOD);
        settle();
        rd(OFS_STATE_VEC, 8'h14);
        rd(OFS_TX_CTRL, 8'hC0);
        ev(EV_EOF);
        // Single byte beaten late: retried without normalization bit
        d = 8'($random(seed));
        wr(OFS_DATA, d);
        wr(OFS_TX_CTRL, 8'hD4);
        arm();
        ex(SYM_NB, 1'b1, 8'h00, ML);
        ex(SYM_BYTE, 1'b0, d, MD);
        ex(SYM_BYTE, 1'b0, d, MD);
        ev(EV_EOD);
        settle();
        rd(OFS_TX_CTRL, 8'hD0);
        ev(EV_EOF);
        // Request set only after the EOD is refused
        wr(OFS_TX_CTRL, 8'hC0);
        ev(EV_EOD);
        wr(OFS_TX_CTRL, 8'hC4);
        rd(OFS_TX_CTRL, 8'hC0);
        repeat (30) @(posedge ref_clk);
        ev(EV_EOF);
        final_report();
    end
endmodule : jit_ifr_ctrl_test
`default_nettype wire
